// ---- core/sgram_ctrl.sv ----
// Purpose: controller end: makes the link clock, issues one command at a time, moves burst data
// Assumes: user holds request until accepted
// Notes: write strobe toggles mid-beat so edges sit in the data eye
`timescale 1ns/10ps
module sgram_ctrl (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // pins
    sgram_if.ctrl pins,
    // user command
    input wire logic req,
    input wire logic [3:0] req_cmd,
    input wire logic [2:0] req_bank,
    input wire logic [11:0] req_addr,
    input wire logic [31:0] wr_data,
    input wire logic [3:0] wr_mask,
    input wire logic wdbi_en,
    output logic ack,
    output logic busy,
    // read data
    output logic [31:0] rd_data,
    output logic rd_valid
);
    localparam int SW = 32 + 4 + 4;
    logic [SW-1:0] s;
    logic [31:0] dq_s;
    logic [3:0] bwm_s, rs_s;
    logic [3:0] rs_d_reg;
    logic [3:0] div_reg;
    logic ck_reg;
    logic ck_rise, ck_fall, ck_mid;
    logic [4:0] beats_reg;
    logic wr_beat;
    logic [3:0] flag;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WRITE = 3'b010,
        ST_READ = 3'b100
    } st_e;
    st_e st_reg;

    sync2 #(.W(SW)) u_sync (
        .clk(clk),
        .reset_n(reset_n),
        .d({pins.data_lines, pins.byte_write_mask, pins.read_strobe}),
        .q(s)
    );
    assign {dq_s, bwm_s, rs_s} = s;

    // link clock divider
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            div_reg <= 4'h0;
            ck_reg <= 1'b0;
        end
        else if (div_reg == 4'(sgram_pkg::CLK_HALF_CYCLES - 1))
        begin
            div_reg <= 4'h0;
            ck_reg <= !ck_reg;
        end
        else div_reg <= div_reg + 4'h1;
    end
    assign ck_rise = (div_reg == 4'(sgram_pkg::CLK_HALF_CYCLES - 1)) && !ck_reg;
    assign ck_fall = (div_reg == 4'(sgram_pkg::CLK_HALF_CYCLES - 1)) && ck_reg;
    assign ck_mid = (div_reg == 4'(sgram_pkg::CLK_HALF_CYCLES / 2 - 1));

    // inversion flags for write lanes with many ones
    always_comb
    begin
        flag = 4'h0;
        for (int i = 0; i < 4; i++)
            if (wdbi_en && $countones(wr_data[i*8 +: 8]) > 4) flag[i] = 1'b1;
    end

    // command issue and burst sequencing
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            st_reg <= ST_IDLE;
            pins.cs_n <= 1'b1;
            {pins.ras_n, pins.cas_n, pins.we_n} <= 3'h7;
            pins.bank_select <= 3'h0;
            pins.addr <= 12'h000;
            ack <= 1'b0;
            beats_reg <= 5'h00;
        end
        else
        begin
            ack <= 1'b0;
            if (ck_fall) // command set up half a period ahead of the rise
            begin
                {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= sgram_pkg::CMD_NOP;
                if (st_reg == ST_IDLE && req && !ack)
                begin
                    {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= req_cmd;
                    pins.bank_select <= req_bank;
                    pins.addr <= req_addr;
                    ack <= 1'b1;
                    beats_reg <= 5'h00;
                    if (req_cmd == sgram_pkg::CMD_WRITE) st_reg <= ST_WRITE;
                    else if (req_cmd == sgram_pkg::CMD_READ) st_reg <= ST_READ;
                end
            end
            unique case (st_reg)
                ST_IDLE: ;
                ST_WRITE, ST_READ:
                    if ((ck_rise || ck_fall) && !ack)
                    begin
                        if (beats_reg == 5'(sgram_pkg::BURST_BEATS + sgram_pkg::READ_GAP_HALVES + 1))
                            st_reg <= ST_IDLE;
                        else beats_reg <= beats_reg + 5'h01;
                    end
            endcase
        end
    end
    assign wr_beat = (st_reg == ST_WRITE) && beats_reg >= 5'h01 && beats_reg <= 5'(sgram_pkg::BURST_BEATS);

    // write data, mask, flags and strobe
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            pins.dq_c_o <= 32'h00000000;
            pins.dq_c_oe_n <= 1'b1;
            pins.bwm_c_o <= 4'h0;
            pins.bwm_c_oe_n <= 1'b1;
            pins.rs_c_o <= 4'h0;
            pins.rs_c_oe_n <= 1'b1;
            pins.write_strobe <= 4'h0;
        end
        else
        begin
            if (wr_beat && (ck_rise || ck_fall))
            begin
                pins.dq_c_o <= wr_data ^ {{8{flag[3]}}, {8{flag[2]}}, {8{flag[1]}}, {8{flag[0]}}};
                pins.dq_c_oe_n <= 1'b0;
                pins.bwm_c_o <= wr_mask;
                pins.bwm_c_oe_n <= 1'b0;
                pins.rs_c_o <= flag;
                pins.rs_c_oe_n <= !wdbi_en;
            end
            else if (st_reg != ST_WRITE)
            begin
                pins.dq_c_oe_n <= 1'b1;
                pins.rs_c_oe_n <= 1'b1;
                // let go of the mask pins so read inversion flags can come back
                pins.bwm_c_oe_n <= 1'b1;
                pins.bwm_c_o <= 4'h0;
            end
            // counted one beat later than the data so each toggle lands mid-beat
            if (ck_mid && st_reg == ST_WRITE && beats_reg >= 5'h02
                && beats_reg <= 5'(sgram_pkg::BURST_BEATS + 1))
                pins.write_strobe <= ~pins.write_strobe;
            else if (st_reg != ST_WRITE) pins.write_strobe <= 4'h0;
        end
    end

    // read capture on each read strobe change
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            rs_d_reg <= 4'h0;
            rd_data <= 32'h00000000;
            rd_valid <= 1'b0;
        end
        else
        begin
            rs_d_reg <= rs_s;
            rd_valid <= 1'b0;
            if (st_reg == ST_READ && rs_s[0] != rs_d_reg[0])
            begin
                for (int i = 0; i < 4; i++)
                    rd_data[i*8 +: 8] <= bwm_s[i] ? ~dq_s[i*8 +: 8] : dq_s[i*8 +: 8];
                rd_valid <= 1'b1;
            end
        end
    end

    // static pins and clock
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            pins.ck <= 1'b0;
            pins.cke_n <= 1'b1;
            pins.scan_enable_pin <= 1'b0;
            pins.mirror_reserved_pin <= 1'b0;
            busy <= 1'b0;
        end
        else
        begin
            pins.ck <= ck_reg;
            pins.cke_n <= 1'b0;
            pins.scan_enable_pin <= 1'b0;
            pins.mirror_reserved_pin <= 1'b0;
            busy <= (st_reg != ST_IDLE);
        end
    end
endmodule

// ---- common/sgram_pkg.sv ----
// Purpose: shared constants for the graphics ddr memory pin interface
// Assumes: 100 MHz core clock on both ends; link clock sampled, not used as a clock
// Notes: command codes are {cs_n, ras_n, cas_n, we_n}
package sgram_pkg;
    localparam int DATA_W = 32;
    localparam int LANES = 4;
    localparam int BANK_W = 3;
    localparam int ADDR_W = 12;
    localparam int BANKS = 8;
    localparam int ROW_W = 12;
    localparam int COL_W = 9;
    localparam int AP_BIT = 8;
    localparam int PRE_ALL_BIT = 8;
    localparam int BURST_BEATS = 8;
    localparam logic [3:0] CMD_NOP = 4'h7;
    localparam logic [3:0] CMD_ACT = 4'h3;
    localparam logic [3:0] CMD_READ = 4'h5;
    localparam logic [3:0] CMD_WRITE = 4'h4;
    localparam logic [3:0] CMD_PRE = 4'h2;
    localparam logic [3:0] CMD_REF = 4'h1;
    localparam logic [3:0] CMD_MRS = 4'h0;
    // controller divides its clock by twice this for the link clock
    localparam int CLK_HALF_CYCLES = 8;
    // beats of delay from read command to first read beat, in link half periods
    localparam int READ_GAP_HALVES = 2;
    localparam logic [ADDR_W-1:0] MODE_RESET = 12'h000;
endpackage

// ---- common/sgram_if.sv ----
// Purpose: pin bundle between controller and memory device
// Assumes: two-way pins carry separate in/out/enable; enable low means driving
// Notes: resolved levels are computed here, pull-low when nobody drives
`timescale 1ns/10ps
interface sgram_if;
    logic ck;
    logic cke_n;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [2:0] bank_select;
    logic [11:0] addr;
    logic scan_enable_pin;
    logic mirror_reserved_pin;
    logic [3:0] write_strobe;
    // data lines, both ends
    logic [31:0] dq_c_o;
    logic dq_c_oe_n;
    logic [31:0] dq_d_o;
    logic dq_d_oe_n;
    logic [31:0] data_lines;
    // byte write mask / read inversion flag
    logic [3:0] bwm_c_o;
    logic bwm_c_oe_n;
    logic [3:0] bwm_d_o;
    logic bwm_d_oe_n;
    logic [3:0] byte_write_mask;
    // read strobe / write inversion flag
    logic [3:0] rs_c_o;
    logic rs_c_oe_n;
    logic [3:0] rs_d_o;
    logic rs_d_oe_n;
    logic [3:0] read_strobe;

    assign data_lines = !dq_c_oe_n ? dq_c_o : (!dq_d_oe_n ? dq_d_o : 32'h00000000);
    assign byte_write_mask = !bwm_c_oe_n ? bwm_c_o : (!bwm_d_oe_n ? bwm_d_o : 4'h0);
    assign read_strobe = !rs_c_oe_n ? rs_c_o : (!rs_d_oe_n ? rs_d_o : 4'h0);

    modport ctrl (
        output ck, cke_n, cs_n, ras_n, cas_n, we_n, bank_select, addr,
        output scan_enable_pin, mirror_reserved_pin, write_strobe,
        output dq_c_o, dq_c_oe_n, bwm_c_o, bwm_c_oe_n, rs_c_o, rs_c_oe_n,
        input data_lines, byte_write_mask, read_strobe
    );
    modport dev (
        input ck, cke_n, cs_n, ras_n, cas_n, we_n, bank_select, addr,
        input scan_enable_pin, mirror_reserved_pin, write_strobe,
        output dq_d_o, dq_d_oe_n, bwm_d_o, bwm_d_oe_n, rs_d_o, rs_d_oe_n,
        input data_lines, byte_write_mask, read_strobe
    );
endinterface

// ---- core/sync2.sv ----
// Purpose: two-flop synchroniser for a bus of levels
// Assumes: each bit is an independent level
// Notes: first stage is read only by the second
`timescale 1ns/10ps
module sync2 #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // level in and out
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;

    // two stages, cleared on reset
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            meta_reg <= '0;
            q <= '0;
        end
        else
        begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule

// ---- core/sgram_device.sv ----
// Purpose: memory device end: decodes commands on link clock edges, moves data both edges
// Assumes: pins synchronised into clk; link clock far slower than clk
// Notes: memory is a small flip-flop array of one row per bank; row address is kept, not decoded
`timescale 1ns/10ps
module sgram_device #(
    parameter int WORDS = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // pins
    sgram_if.dev pins,
    // user side status
    output logic [11:0] mode_value,
    output logic [7:0] bank_open,
    output logic [11:0] last_row,
    output logic [8:0] last_col,
    output logic masked_beat
);
    localparam int SW = 1 + 1 + 4 + 3 + 12 + 4 + 32 + 4;
    logic [SW-1:0] raw;
    logic [SW-1:0] s;
    logic ck_s, ck_d_reg;
    logic [3:0] cmd_s;
    logic [2:0] ba_s;
    logic [11:0] a_s;
    logic [3:0] bwm_s;
    logic [31:0] dq_s;
    logic [3:0] rs_s;
    logic cke_n_s;
    logic rise, fall, edge_any;
    logic wr_active_reg, rd_active_reg;
    logic [3:0] beat_reg;
    logic [2:0] bank_reg;
    logic [2:0] colb_reg;
    logic ap_reg;
    logic [3:0] rd_gap_reg;
    logic rdbi_en, wdbi_en;
    logic [31:0] mem_reg [sgram_pkg::BANKS][WORDS];
    logic [31:0] rd_word;
    logic [31:0] wr_word;
    logic [3:0] rd_flag;

    assign raw = {pins.ck, pins.cke_n, pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n,
                  pins.bank_select, pins.addr, pins.byte_write_mask, pins.data_lines, pins.read_strobe};

    sync2 #(.W(SW)) u_sync (
        .clk(clk),
        .reset_n(reset_n),
        .d(raw),
        .q(s)
    );

    assign {ck_s, cke_n_s, cmd_s, ba_s, a_s, bwm_s, dq_s, rs_s} = s;
    assign rise = ck_s && !ck_d_reg;
    assign fall = !ck_s && ck_d_reg;
    assign edge_any = rise || fall;
    // inversion enables live in mode bits above the latency field (chosen)
    assign rdbi_en = mode_value[10];
    assign wdbi_en = mode_value[11];
    // write beat with inverted lanes restored; flags only count when write inversion is on
    assign wr_word = undo_inv(dq_s, wdbi_en ? rs_s : 4'h0);

    // restore an inverted byte lane by its flag
    function automatic logic [31:0] undo_inv(input logic [31:0] d, input logic [3:0] f);
        logic [31:0] r;
        r = d;
        for (int i = 0; i < 4; i++)
            if (f[i]) r[i*8 +: 8] = ~d[i*8 +: 8];
        return r;
    endfunction

    // link clock edge finder
    always_ff @(posedge clk)
    begin
        if (!reset_n) ck_d_reg <= 1'b0;
        else ck_d_reg <= ck_s;
    end

    // command decode on rising link edge; select high masks all
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            mode_value <= sgram_pkg::MODE_RESET;
            bank_open <= 8'h00;
            last_row <= 12'h000;
            last_col <= 9'h000;
            wr_active_reg <= 1'b0;
            rd_active_reg <= 1'b0;
            beat_reg <= 4'h0;
            bank_reg <= 3'h0;
            colb_reg <= 3'h0;
            ap_reg <= 1'b0;
            rd_gap_reg <= 4'h0;
        end
        else
        begin
            if (rise && !cke_n_s && !cmd_s[3])
            begin
                unique case (cmd_s)
                    sgram_pkg::CMD_ACT:
                    begin
                        bank_open[ba_s] <= 1'b1;
                        last_row <= a_s[sgram_pkg::ROW_W-1:0];
                    end
                    sgram_pkg::CMD_PRE:
                    begin
                        if (a_s[sgram_pkg::PRE_ALL_BIT]) bank_open <= 8'h00;
                        else bank_open[ba_s] <= 1'b0;
                    end
                    sgram_pkg::CMD_MRS: mode_value <= a_s;
                    sgram_pkg::CMD_WRITE, sgram_pkg::CMD_READ:
                    begin
                        last_col <= {a_s[9], a_s[7:0]};
                        ap_reg <= a_s[sgram_pkg::AP_BIT];
                        bank_reg <= ba_s;
                        colb_reg <= a_s[5:3];
                        beat_reg <= 4'h0;
                        wr_active_reg <= (cmd_s == sgram_pkg::CMD_WRITE);
                        rd_active_reg <= (cmd_s == sgram_pkg::CMD_READ);
                        rd_gap_reg <= 4'(sgram_pkg::READ_GAP_HALVES);
                    end
                    default: ;
                endcase
            end
            // beats count on every link edge; the nop rise between beats must not stall them
            if (edge_any && (wr_active_reg || rd_active_reg))
            begin
                if (rd_active_reg && rd_gap_reg != 4'h0) rd_gap_reg <= rd_gap_reg - 4'h1;
                else if (beat_reg == 4'(sgram_pkg::BURST_BEATS - 1))
                begin
                    wr_active_reg <= 1'b0;
                    rd_active_reg <= 1'b0;
                    if (ap_reg) bank_open[bank_reg] <= 1'b0;
                    beat_reg <= 4'h0;
                end
                else beat_reg <= beat_reg + 4'h1;
            end
        end
    end

    // write beats stored per lane on each link edge unless masked
    always_ff @(posedge clk)
    begin
        if (!reset_n) masked_beat <= 1'b0;
        else if (edge_any && wr_active_reg)
        begin
            masked_beat <= |bwm_s;
            for (int i = 0; i < 4; i++)
                if (!bwm_s[i])
                    mem_reg[bank_reg][colb_reg][i*8 +: 8] <= wr_word[i*8 +: 8];
        end
    end

    // read word and inversion flags: invert a lane with more than four ones
    always_comb
    begin
        rd_word = mem_reg[bank_reg][colb_reg];
        rd_flag = 4'h0;
        for (int i = 0; i < 4; i++)
            if (rdbi_en && $countones(rd_word[i*8 +: 8]) > 4) rd_flag[i] = 1'b1;
    end

    // read drive: strobes toggle with each beat so edges line up with data
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            pins.dq_d_o <= 32'h00000000;
            pins.dq_d_oe_n <= 1'b1;
            pins.rs_d_o <= 4'h0;
            pins.rs_d_oe_n <= 1'b1;
            pins.bwm_d_o <= 4'h0;
            pins.bwm_d_oe_n <= 1'b1;
        end
        else if (edge_any && rd_active_reg && rd_gap_reg == 4'h0)
        begin
            pins.dq_d_o <= undo_inv(rd_word, rd_flag);
            pins.dq_d_oe_n <= 1'b0;
            pins.rs_d_o <= beat_reg[0] ? 4'h0 : 4'hF;
            pins.rs_d_oe_n <= 1'b0;
            pins.bwm_d_o <= rd_flag;
            pins.bwm_d_oe_n <= !rdbi_en;
        end
        else if (!rd_active_reg)
        begin
            pins.dq_d_oe_n <= 1'b1;
            pins.rs_d_oe_n <= 1'b1;
            pins.bwm_d_oe_n <= 1'b1;
            pins.rs_d_o <= 4'h0;
        end
    end
endmodule

// ---- bench/sgram_pins_checker.sv ----
// Purpose: pin-level protocol checks on the interface between controller and device
// Assumes: one clk domain; link pins are seen as levels
// Notes: watches only interface signals, both ends are design code
`timescale 1ns/10ps
module sgram_pins_checker (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // command and strobe pins
    input wire logic ck,
    input wire logic cke_n,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [2:0] bank_select,
    input wire logic [11:0] addr,
    input wire logic scan_enable_pin,
    input wire logic mirror_reserved_pin,
    input wire logic [3:0] write_strobe,
    // two-way pin halves
    input wire logic [31:0] dq_c_o,
    input wire logic dq_c_oe_n,
    input wire logic [31:0] dq_d_o,
    input wire logic dq_d_oe_n,
    input wire logic bwm_c_oe_n,
    input wire logic bwm_d_oe_n,
    input wire logic rs_c_oe_n,
    input wire logic rs_d_oe_n,
    input wire logic [3:0] read_strobe
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    // tie-offs never move, the device has no use for them here
    property p_scan_low; scan_enable_pin == 1'b0; endproperty
    a_scan_low: assert property (p_scan_low) else $error("scan enable not low");
    property p_mirror_low; mirror_reserved_pin == 1'b0; endproperty
    a_mirror_low: assert property (p_mirror_low) else $error("mirror pin not low");
    // two drivers on the data bus would fight
    property p_one_driver; !(!dq_c_oe_n && !dq_d_oe_n); endproperty
    a_one_driver: assert property (p_one_driver) else $error("both ends drive data");
    property p_cke_access; (!dq_c_oe_n || !dq_d_oe_n) |-> !cke_n; endproperty
    a_cke_access: assert property (p_cke_access) else $error("clock enable high in access");
    // flag pins turn round with the data direction
    property p_mask_dir; !bwm_d_oe_n |-> bwm_c_oe_n && dq_c_oe_n; endproperty
    a_mask_dir: assert property (p_mask_dir) else $error("mask flags driven during write");
    property p_rs_dir; !rs_c_oe_n |-> rs_d_oe_n && dq_d_oe_n; endproperty
    a_rs_dir: assert property (p_rs_dir) else $error("strobe pins driven both ways");
    property p_rd_edge; (!dq_d_oe_n && $changed(dq_d_o)) |-> $changed(read_strobe); endproperty
    a_rd_edge: assert property (p_rd_edge) else $error("read data moved without strobe");
    property p_wr_centre; (!dq_c_oe_n && $changed(dq_c_o)) |-> $stable(write_strobe); endproperty
    a_wr_centre: assert property (p_wr_centre) else $error("write strobe moved with data");
    property p_wr_in_burst; $changed(write_strobe) |-> !dq_c_oe_n; endproperty
    a_wr_in_burst: assert property (p_wr_in_burst) else $error("write strobe moved outside data");
    // the device samples pins some cycles after the edge, so they must hold
    property p_cmd_stands; $changed({cs_n, ras_n, cas_n, we_n})
        |=> $stable({cs_n, ras_n, cas_n, we_n, bank_select, addr})[*8]; endproperty
    a_cmd_stands: assert property (p_cmd_stands) else $error("command pins moved early");
    property p_ck_half; $rose(ck) |-> ck[*8] ##1 !ck; endproperty
    a_ck_half: assert property (p_ck_half) else $error("link clock half period wrong");
    // an inverted lane never carries more ones than it saves
    property p_dbi_lanes; (!dq_d_oe_n && !bwm_d_oe_n) |-> $countones(dq_d_o[7:0]) <= 4
        && $countones(dq_d_o[15:8]) <= 4 && $countones(dq_d_o[23:16]) <= 4 && $countones(dq_d_o[31:24]) <= 4;
    endproperty
    a_dbi_lanes: assert property (p_dbi_lanes) else $error("lane sent with too many ones");
endmodule

// ---- bench/testbench.sv ----
// Purpose: drives the controller user side and watches device status across the pins
// Assumes: both ends share clk; stimulus changes at the falling edge
// Notes: table rows hold plain commands; inversion, masking and reset are hand tests
`timescale 1ns/10ps
module testbench;
    typedef struct {
        logic [3:0] cmd;
        logic [2:0] bank;
        logic [11:0] addr;
        logic [31:0] wd;
        logic [7:0] open;
    } row_s;
    logic clk, reset_n, req, wdbi_en, ack, busy, rd_valid, masked_beat;
    logic [3:0] req_cmd, wr_mask;
    logic [2:0] req_bank;
    logic [11:0] req_addr, mode_value, last_row;
    logic [31:0] wr_data, rd_data, got;
    logic [7:0] bank_open;
    logic [8:0] last_col;
    int miscompares, total_checks, beats;
    row_s rows [9];

    sgram_if pins ();
    sgram_ctrl u_sgram_ctrl (.clk, .reset_n, .pins, .req, .req_cmd, .req_bank, .req_addr, .wr_data,
        .wr_mask, .wdbi_en, .ack, .busy, .rd_data, .rd_valid);
    sgram_device u_sgram_device (.clk, .reset_n, .pins, .mode_value, .bank_open, .last_row,
        .last_col, .masked_beat);
    sgram_pins_checker u_sgram_pins_checker (.clk, .reset_n, .ck(pins.ck), .cke_n(pins.cke_n),
        .cs_n(pins.cs_n), .ras_n(pins.ras_n), .cas_n(pins.cas_n), .we_n(pins.we_n),
        .bank_select(pins.bank_select), .addr(pins.addr), .scan_enable_pin(pins.scan_enable_pin),
        .mirror_reserved_pin(pins.mirror_reserved_pin), .write_strobe(pins.write_strobe),
        .dq_c_o(pins.dq_c_o), .dq_c_oe_n(pins.dq_c_oe_n), .dq_d_o(pins.dq_d_o), .dq_d_oe_n(pins.dq_d_oe_n),
        .bwm_c_oe_n(pins.bwm_c_oe_n), .bwm_d_oe_n(pins.bwm_d_oe_n), .rs_c_oe_n(pins.rs_c_oe_n),
        .rs_d_oe_n(pins.rs_d_oe_n),
        .read_strobe(pins.read_strobe));

    // free running core clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // verdict and end of run
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic check(string name, logic [31:0] exp, logic [31:0] seen);
        total_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // a used-up wait counts as a mismatch and stops the run
    task automatic bound(int n, int lim);
        if (n >= lim)
        begin
            miscompares++;
            $display("mismatch wait_limit expected %0d seen %0d", lim - 1, n);
            complete_run();
        end
    endtask

    // hold req until ack, then watch until quiet, keeping the last read beat
    task automatic issue(logic [3:0] c, logic [2:0] b, logic [11:0] a, logic [31:0] d, logic [3:0] m);
        int n;
        int quiet;
        n = 0;
        quiet = 0;
        req_cmd = c;
        req_bank = b;
        req_addr = a;
        wr_data = d;
        wr_mask = m;
        req = 1'b1;
        while (ack !== 1'b1 && n < 200)
        begin
            @(negedge clk);
            n++;
        end
        bound(n, 200);
        req = 1'b0;
        beats = 0;
        // a read that returns nothing must not pass on an earlier word
        got = 32'h00000000;
        // busy can fall before the device has acted on the link edge, so wait for a quiet spell
        while (quiet < 24 && n < 600)
        begin
            @(negedge clk);
            n++;
            quiet = (busy === 1'b0) ? quiet + 1 : 0;
            if (rd_valid === 1'b1)
            begin
                beats++;
                got = rd_data;
            end
        end
        bound(n, 600);
    endtask

    // main sequence
    initial
    begin
        reset_n = 1'b0;
        req = 1'b0;
        req_cmd = sgram_pkg::CMD_NOP;
        req_bank = 3'h0;
        req_addr = 12'h000;
        wr_data = 32'h00000000;
        wr_mask = 4'h0;
        wdbi_en = 1'b0;
        rows[0] = '{sgram_pkg::CMD_MRS, 3'h0, 12'h000, 32'h00000000, 8'h00};
        rows[1] = '{sgram_pkg::CMD_ACT, 3'h2, 12'hABC, 32'h00000000, 8'h04};
        rows[2] = '{sgram_pkg::CMD_WRITE, 3'h2, 12'h018, 32'h12345678, 8'h04};
        rows[3] = '{sgram_pkg::CMD_READ, 3'h2, 12'h018, 32'h12345678, 8'h04};
        rows[4] = '{sgram_pkg::CMD_ACT, 3'h5, 12'h3FF, 32'h00000000, 8'h24};
        rows[5] = '{sgram_pkg::CMD_WRITE, 3'h5, 12'h220, 32'hA5C30FF0, 8'h24};
        rows[6] = '{sgram_pkg::CMD_READ, 3'h5, 12'h220, 32'hA5C30FF0, 8'h24};
        rows[7] = '{sgram_pkg::CMD_PRE, 3'h2, 12'h000, 32'h00000000, 8'h20};
        rows[8] = '{sgram_pkg::CMD_PRE, 3'h0, 12'h100, 32'h00000000, 8'h00};
        repeat (6) @(negedge clk);
        reset_n = 1'b1;
        @(negedge clk);
        foreach (rows[i])
        begin
            issue(rows[i].cmd, rows[i].bank, rows[i].addr, rows[i].wd, 4'h0);
            check("bank_open", 32'(rows[i].open), 32'(bank_open));
            if (rows[i].cmd == sgram_pkg::CMD_ACT)
                check("last_row", 32'(rows[i].addr), 32'(last_row));
            if (rows[i].cmd == sgram_pkg::CMD_MRS)
                check("mode_value", 32'(rows[i].addr), 32'(mode_value));
            if (rows[i].cmd == sgram_pkg::CMD_READ || rows[i].cmd == sgram_pkg::CMD_WRITE)
                check("last_col", 32'({rows[i].addr[9], rows[i].addr[7:0]}), 32'(last_col));
            if (rows[i].cmd == sgram_pkg::CMD_READ)
            begin
                check("rd_data", rows[i].wd, got);
                check("beats", 32'(sgram_pkg::BURST_BEATS), 32'(beats));
            end
        end
        // select high: the activate must leave every bank closed
        issue({1'b1, sgram_pkg::CMD_ACT[2:0]}, 3'h7, 12'h001, 32'h00000000, 4'h0);
        check("bank_open", 32'h00000000, 32'(bank_open));
        // both inversion modes on, lanes with many ones get flagged
        wdbi_en = 1'b1;
        issue(sgram_pkg::CMD_MRS, 3'h0, 12'hC00, 32'h00000000, 4'h0);
        check("mode_value", 32'h00000C00, 32'(mode_value));
        issue(sgram_pkg::CMD_ACT, 3'h1, 12'h010, 32'h00000000, 4'h0);
        issue(sgram_pkg::CMD_WRITE, 3'h1, 12'h000, 32'hFE7F0181, 4'h0);
        check("masked_beat", 32'h00000000, 32'(masked_beat));
        issue(sgram_pkg::CMD_READ, 3'h1, 12'h000, 32'h00000000, 4'h0);
        check("rd_data", 32'hFE7F0181, got);
        // fully masked write keeps the stored word
        issue(sgram_pkg::CMD_WRITE, 3'h1, 12'h000, 32'h00000000, 4'hF);
        check("masked_beat", 32'h00000001, 32'(masked_beat));
        issue(sgram_pkg::CMD_READ, 3'h1, 12'h000, 32'h00000000, 4'h0);
        check("rd_data", 32'hFE7F0181, got);
        // auto precharge closes the bank when the burst ends
        issue(sgram_pkg::CMD_WRITE, 3'h1, 12'h108, 32'h0F0F0F0F, 4'h0);
        check("bank_open", 32'h00000000, 32'(bank_open));
        issue(sgram_pkg::CMD_ACT, 3'h6, 12'h800, 32'h00000000, 4'h0);
        check("bank_open", 32'h00000040, 32'(bank_open));
        // second reset in mid-run clears status
        reset_n = 1'b0;
        wdbi_en = 1'b0;
        repeat (6) @(negedge clk);
        reset_n = 1'b1;
        @(negedge clk);
        check("bank_open", 32'h00000000, 32'(bank_open));
        check("mode_value", 32'(sgram_pkg::MODE_RESET), 32'(mode_value));
        complete_run();
    end
endmodule
